// >>> hdl/fpet_pkg.sv
package fpet_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int DIV_W  = 4;
  localparam int CNT_W  = 8;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [15:0] IDX_PRESCALE  = 16'hF8C4;
  localparam logic [15:0] IDX_START     = 16'hF8C6;
  localparam logic [15:0] IDX_TRAN      = 16'hF8CA;
  localparam logic [15:0] IDX_PROG      = 16'hF8D0;
  localparam logic [15:0] IDX_PERASE    = 16'hF8D2;
  localparam logic [15:0] IDX_SERASE    = 16'hF8D4;
  localparam logic [15:0] IDX_END       = 16'hF8D8;
  localparam logic [15:0] IDX_SEND      = 16'hF8DC;
  localparam logic [15:0] IDX_RCV       = 16'hF8DE;
  localparam logic [15:0] IDX_CMD       = 16'hF8E0;
  localparam logic [15:0] IDX_STATUS    = 16'hF8E2;

  // register selectors: 0..7 index the timing count array
  localparam logic [3:0] SEL_START      = 4'h0;
  localparam logic [3:0] SEL_TRAN       = 4'h1;
  localparam logic [3:0] SEL_PROG       = 4'h2;
  localparam logic [3:0] SEL_PERASE     = 4'h3;
  localparam logic [3:0] SEL_SERASE     = 4'h4;
  localparam logic [3:0] SEL_END        = 4'h5;
  localparam logic [3:0] SEL_SEND       = 4'h6;
  localparam logic [3:0] SEL_RCV        = 4'h7;
  localparam logic [3:0] SEL_PRESCALE   = 4'h8;
  localparam logic [3:0] SEL_CMD        = 4'h9;
  localparam logic [3:0] SEL_STATUS     = 4'hA;
  localparam logic [3:0] SEL_NONE       = 4'hF;
  localparam int         NUM_TIM        = 8;

  localparam logic [DIV_W-1:0] PRESCALE_RESET = 4'h0;
  localparam logic [CNT_W-1:0] TIM_RESET [0:NUM_TIM-1] = '{
    8'h14, 8'h28, 8'h0A, 8'h09, 8'h09, 8'h14, 8'h32, 8'h04
  };

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OP_LSB   = 1;
  localparam int STAT_DONE_BIT = 3;

  typedef enum logic [1:0] {
    FPET_OP_NONE,
    FPET_OP_PROG,
    FPET_OP_PAGE,
    FPET_OP_SECT
  } fpet_op_t;

endpackage

// >>> hdl/fpet_tmr_if.sv
`timescale 1ns/1ps
interface fpet_tmr_if;
  import fpet_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic [DIV_W-1:0] div;
  logic             done;
  modport ctl (output load, output count, output div, input done);
  modport tmr (input load, input count, input div, output done);
endinterface

// >>> hdl/fpet_phase_timer.sv
`timescale 1ns/1ps
module fpet_phase_timer #(
  parameter int DIV_BITS = fpet_pkg::DIV_W,
  parameter int CNT_BITS = fpet_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic nrst,
  fpet_tmr_if.tmr  tif
);
  import fpet_pkg::*;

  if (DIV_BITS != DIV_W || CNT_BITS != CNT_W) begin : g_bad_width
    $error("fpet_phase_timer widths must match the timer interface");
  end

  logic [DIV_BITS-1:0] presc_reg;
  logic [CNT_BITS-1:0] cnt_reg;
  logic                run_reg;
  logic                done_reg;

  assign tif.done = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler restarts on every load so each phase starts on a full tick
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      presc_reg <= '0;
      cnt_reg   <= '0;
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else if (tif.load) begin
      presc_reg <= '0;
      cnt_reg   <= tif.count;
      run_reg   <= 1'b1;
      done_reg  <= 1'b0;
    end else if (run_reg) begin
      done_reg <= 1'b0;
      if (presc_reg == tif.div) begin // see RULE_01
        presc_reg <= '0;
        // a count of zero still lasts one tick
        if (cnt_reg <= CNT_BITS'(1)) begin // see RULE_12
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - CNT_BITS'(1);
        end
      end else begin
        presc_reg <= presc_reg + DIV_BITS'(1);
      end
    end else begin
      done_reg <= 1'b0;
    end
  end

endmodule

// >>> hdl/fpet_top.sv
// Notes on behaviour
// RULE_01: a four-bit divider in the low bits of the prescale register sets the tick ratio, upper bits read zero, reset zero.
// RULE_02: the start phase lasts the start delay count, reset 0x14.
// RULE_03: transition phases around the pulse last the transition count, reset 0x28.
// RULE_04: the program pulse lasts the program pulse count, reset 0x0A.
// RULE_05: the page erase pulse lasts the page erase count, reset 0x09.
// RULE_06: the section erase pulse lasts its own count, reset 0x09.
// RULE_07: program and page erase close with the end delay count, reset 0x14.
// RULE_08: section erase closes with its own end delay count, reset 0x32.
// RULE_09: a recovery phase of the recovery count, reset 0x04, separates two accesses.
// RULE_10: software loads all counts and the divider to suit the core clock before starting work.
// RULE_11: the engine reads busy from start until the operation is complete, ready only after.
// RULE_12: every phase counts ticks of the core clock over the divider and advances when its count runs out.
`timescale 1ns/1ps
module fpet_top (
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [fpet_pkg::ADDR_W-1:0] paddr,
  input  wire logic [fpet_pkg::DATA_W-1:0] pwdata,
  output logic      [fpet_pkg::DATA_W-1:0] prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic                          flash_engine_busy,
  output logic                          flash_prog_pulse,
  output logic                          flash_erase_pulse,
  output logic                          flash_section_mode,
  output logic                          flash_op_done
);
  import fpet_pkg::*;

  typedef enum logic [2:0] {
    FPET_IDLE,
    FPET_START,
    FPET_TRAN_IN,
    FPET_PULSE,
    FPET_TRAN_OUT,
    FPET_END,
    FPET_RECOVER
  } fpet_state_t;

  logic [DIV_W-1:0]  prescale_reg;
  logic [CNT_W-1:0]  tim_reg [0:NUM_TIM-1];
  fpet_state_t       state_reg;
  fpet_state_t       state_next;
  fpet_op_t          op_reg;
  fpet_op_t          op_next;
  logic              load_reg;
  logic              load_next;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic              done_flag_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic              busy_reg;
  logic              prog_reg;
  logic              erase_reg;
  logic              sect_reg;
  logic              op_done_reg;
  logic [DATA_W-1:0] rdata;
  logic [3:0]        regsel;
  logic              access;
  logic              commit_wr;
  logic              start_req;
  logic              finish;

  fpet_tmr_if tif ();

  ////////////////////////////////////////////////////////////////////////////
  // decode and phase helpers

  function automatic logic [3:0] sel_of(input logic [15:0] idx);
    case (idx)
      IDX_START:    sel_of = SEL_START;
      IDX_TRAN:     sel_of = SEL_TRAN;
      IDX_PROG:     sel_of = SEL_PROG;
      IDX_PERASE:   sel_of = SEL_PERASE;
      IDX_SERASE:   sel_of = SEL_SERASE;
      IDX_END:      sel_of = SEL_END;
      IDX_SEND:     sel_of = SEL_SEND;
      IDX_RCV:      sel_of = SEL_RCV;
      IDX_PRESCALE: sel_of = SEL_PRESCALE;
      IDX_CMD:      sel_of = SEL_CMD;
      IDX_STATUS:   sel_of = SEL_STATUS;
      default:      sel_of = SEL_NONE;
    endcase
  endfunction

  function automatic fpet_state_t advance(input fpet_state_t s);
    case (s)
      FPET_START:    advance = FPET_TRAN_IN;
      FPET_TRAN_IN:  advance = FPET_PULSE;
      FPET_PULSE:    advance = FPET_TRAN_OUT;
      FPET_TRAN_OUT: advance = FPET_END;
      FPET_END:      advance = FPET_RECOVER;
      default:       advance = FPET_IDLE;
    endcase
  endfunction

  // which timing count a phase is loaded from
  function automatic logic [2:0] phase_sel(input fpet_state_t s, input fpet_op_t op);
    case (s)
      FPET_START:    phase_sel = SEL_START[2:0]; // see RULE_02
      FPET_TRAN_IN,
      FPET_TRAN_OUT: phase_sel = SEL_TRAN[2:0]; // see RULE_03
      FPET_PULSE: begin
        case (op)
          FPET_OP_PROG: phase_sel = SEL_PROG[2:0]; // see RULE_04
          FPET_OP_PAGE: phase_sel = SEL_PERASE[2:0]; // see RULE_05
          default:      phase_sel = SEL_SERASE[2:0]; // see RULE_06
        endcase
      end
      FPET_END: begin
        if (op == FPET_OP_SECT) begin
          phase_sel = SEL_SEND[2:0]; // see RULE_08
        end else begin
          phase_sel = SEL_END[2:0]; // see RULE_07
        end
      end
      default:       phase_sel = SEL_RCV[2:0]; // see RULE_09
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, then pready for a single cycle

  assign regsel    = (paddr[1:0] == 2'b00) ? sel_of(paddr[ADDR_W-1:2]) : SEL_NONE;
  assign access    = psel & penable & ~pready_reg;
  assign commit_wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  always_comb begin
    rdata = '0;
    case (regsel)
      SEL_PRESCALE: rdata[DIV_W-1:0] = prescale_reg; // see RULE_01
      SEL_CMD:      rdata[1:0] = op_reg;
      SEL_STATUS: begin
        rdata[STAT_BUSY_BIT]                 = busy_reg; // see RULE_11
        rdata[STAT_OP_LSB+1:STAT_OP_LSB]     = op_reg;
        rdata[STAT_DONE_BIT]                 = done_flag_reg;
      end
      SEL_NONE:     rdata = '0;
      default:      rdata[CNT_W-1:0] = tim_reg[regsel[2:0]];
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= access;
      // error stands only in the answer cycle, like pready
      pslverr_reg <= access && regsel == SEL_NONE;
      if (access) begin
        prdata_reg <= pwrite ? '0 : rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing registers; rewriting a count mid-operation affects only later phases, rewriting the divider also the running phase

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prescale_reg <= PRESCALE_RESET; // see RULE_01
    end else if (commit_wr && regsel == SEL_PRESCALE) begin
      prescale_reg <= pwdata[DIV_W-1:0]; // see RULE_01
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TIM; i++) begin
        tim_reg[i] <= TIM_RESET[i];
      end
    end else if (commit_wr && regsel[3] == 1'b0) begin
      tim_reg[regsel[2:0]] <= pwdata[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // commands while busy are dropped so an operation is never cut short
  assign start_req = commit_wr && regsel == SEL_CMD && pwdata[1:0] != 2'b00
                     && state_reg == FPET_IDLE;
  assign finish    = state_reg == FPET_RECOVER && tif.done;

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    load_next  = 1'b0;
    count_next = count_reg;
    case (state_reg)
      FPET_IDLE: begin
        if (start_req) begin
          op_next    = fpet_op_t'(pwdata[1:0]);
          state_next = FPET_START;
          load_next  = 1'b1;
          count_next = tim_reg[SEL_START[2:0]]; // see RULE_02
        end
      end
      FPET_START, FPET_TRAN_IN, FPET_PULSE, FPET_TRAN_OUT, FPET_END, FPET_RECOVER: begin
        if (tif.done) begin // see RULE_12
          state_next = advance(state_reg);
          if (state_next == FPET_IDLE) begin
            op_next = FPET_OP_NONE;
          end else begin
            load_next  = 1'b1;
            count_next = tim_reg[phase_sel(state_next, op_reg)];
          end
        end
      end
      default: begin
        state_next = FPET_IDLE;
        op_next    = FPET_OP_NONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= FPET_IDLE;
      op_reg    <= FPET_OP_NONE;
      load_reg  <= 1'b0;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      load_reg  <= load_next;
      count_reg <= count_next;
    end
  end

  assign tif.load  = load_reg;
  assign tif.count = count_reg;
  assign tif.div   = prescale_reg;

  fpet_phase_timer #(
    .DIV_BITS (DIV_W),
    .CNT_BITS (CNT_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tif     (tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flash-side outputs, registered from the next state

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg    <= 1'b0;
      prog_reg    <= 1'b0;
      erase_reg   <= 1'b0;
      sect_reg    <= 1'b0;
      op_done_reg <= 1'b0;
    end else begin
      busy_reg    <= state_next != FPET_IDLE; // see RULE_11
      prog_reg    <= state_next == FPET_PULSE && op_next == FPET_OP_PROG;
      erase_reg   <= state_next == FPET_PULSE && op_next != FPET_OP_PROG;
      sect_reg    <= op_next == FPET_OP_SECT;
      op_done_reg <= finish;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_flag_reg <= 1'b0;
    end else if (finish) begin
      done_flag_reg <= 1'b1;
    end else if (commit_wr && regsel == SEL_STATUS && pwdata[STAT_DONE_BIT]) begin
      done_flag_reg <= 1'b0;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign flash_engine_busy  = busy_reg;
  assign flash_prog_pulse   = prog_reg;
  assign flash_erase_pulse  = erase_reg;
  assign flash_section_mode = sect_reg;
  assign flash_op_done      = op_done_reg;

endmodule

// >>> testbench/fpet_flash_model.sv
`timescale 1ns/1ps
module fpet_flash_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clr,
  input  wire logic        prog_pulse,
  input  wire logic        erase_pulse,
  input  wire logic        section_mode,
  output logic      [15:0] prog_len,
  output logic      [15:0] erase_len,
  output logic             sect_seen
);
  // the array measures how long each pulse is held and flags an erase in section mode; it drives nothing back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prog_len  <= 16'h0000;
      erase_len <= 16'h0000;
      sect_seen <= 1'b0;
    end else if (clr) begin
      prog_len  <= 16'h0000;
      erase_len <= 16'h0000;
      sect_seen <= 1'b0;
    end else begin
      if (prog_pulse) prog_len <= prog_len + 16'h0001;
      if (erase_pulse) erase_len <= erase_len + 16'h0001;
      if (erase_pulse && section_mode) sect_seen <= 1'b1;
    end
  end
endmodule

// >>> testbench/fpet_top_properties.sv
`timescale 1ns/1ps
module fpet_top_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_engine_busy,
  input wire logic flash_prog_pulse,
  input wire logic flash_erase_pulse,
  input wire logic flash_section_mode,
  input wire logic flash_op_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_one_wait;
    !pready ##1 pready ##1 !pready;
  endsequence
  // start and first transition phase each take at least three cycles
  sequence s_quiet_start;
    !(flash_prog_pulse || flash_erase_pulse) [*6];
  endsequence

  AST_ONE_WAIT_STATE: assert property (psel && $rose(penable) |-> s_one_wait)
    else $error("apb answer not after exactly one wait state");
  AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("slave error outside the answer cycle");
  AST_PULSES_EXCLUSIVE: assert property (!(flash_prog_pulse && flash_erase_pulse))
    else $error("program and erase pulse together");
  AST_PULSE_IN_BUSY: assert property (flash_prog_pulse || flash_erase_pulse |-> flash_engine_busy)
    else $error("pulse while engine idle");
  AST_START_BEFORE_PULSE: assert property ($rose(flash_engine_busy) |-> s_quiet_start)
    else $error("pulse began before start and transition phases");
  AST_DONE_ENDS_BUSY: assert property (flash_op_done |-> !flash_engine_busy && $past(flash_engine_busy))
    else $error("done not at the end of busy");
  AST_DONE_ONE_CYCLE: assert property (flash_op_done |=> !flash_op_done)
    else $error("done longer than one cycle");
  AST_SECT_NO_PROG: assert property (flash_section_mode |-> flash_engine_busy && !flash_prog_pulse)
    else $error("section mode outside a section erase");
endmodule

bind fpet_top fpet_top_checker fpet_top_checker_inst (
  .ref_clk            (ref_clk),
  .nrst               (nrst),
  .psel               (psel),
  .penable            (penable),
  .pready             (pready),
  .pslverr            (pslverr),
  .flash_engine_busy  (flash_engine_busy),
  .flash_prog_pulse   (flash_prog_pulse),
  .flash_erase_pulse  (flash_erase_pulse),
  .flash_section_mode (flash_section_mode),
  .flash_op_done      (flash_op_done)
);

// >>> testbench/test_flash_program_erase_timing.sv
`timescale 1ns/1ps
module test_flash_program_erase_timing;
  import fpet_pkg::*;
  logic              ref_clk = 1'b0;
  logic              nrst    = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic              clr     = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [DATA_W-1:0] pwdata  = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready, pslverr, busy, prog_p, erase_p, sect_m, op_done, sect_seen;
  logic [15:0]       prog_len, erase_len;
  int                err_count    = 0;
  int                total_checks = 0;
  int                busy_cnt     = 0;
  integer            seed         = 59346;
  logic [15:0]       idx_tab [0:8] = '{IDX_PRESCALE, IDX_START, IDX_TRAN, IDX_PROG,
                                       IDX_PERASE, IDX_SERASE, IDX_END, IDX_SEND, IDX_RCV};
  logic [7:0]        model [0:8] = '{8'h00, 8'h14, 8'h28, 8'h0A, 8'h09, 8'h09, 8'h14, 8'h32, 8'h04};

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (busy === 1'b1) busy_cnt++;

  fpet_top fpet_top_inst (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_engine_busy(busy), .flash_prog_pulse(prog_p),
    .flash_erase_pulse(erase_p), .flash_section_mode(sect_m), .flash_op_done(op_done));
  fpet_flash_model fpet_flash_model_inst (.ref_clk(ref_clk), .nrst(nrst), .clr(clr),
    .prog_pulse(prog_p), .erase_pulse(erase_p), .section_mode(sect_m),
    .prog_len(prog_len), .erase_len(erase_len), .sect_seen(sect_seen));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one transfer; waits for pready however long it takes, bounded only by the watchdog
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // phase length in core cycles: count 0 acts as 1, tick is divider plus one
  function automatic int ph(input logic [7:0] n);
    return ((n == 8'h00) ? 1 : int'(n)) * (int'(model[0][3:0]) + 1) + 2;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic        er;
    int          exp_busy;
    int          pulse;
    int          n;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, idx_tab[i], 32'h0, rd, er);
      chk(rd, {24'h0, model[i]});
    end
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, idx_tab[i], 32'hFFFFFFFF, rd, er);
      apb(1'b0, idx_tab[i], 32'h0, rd, er);
      chk(rd, (i == 0) ? 32'h0000000F : 32'h000000FF);
    end
    apb(1'b0, 16'h0001, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h00000001);
    for (int op = 1; op < 4; op++) begin
      repeat (2) begin
        for (int i = 0; i < 9; i++) begin
          model[i] = 8'($random(seed)) & ((i == 0) ? 8'h03 : 8'h07);
          apb(1'b1, idx_tab[i], {24'h0, model[i]}, rd, er);
        end
        pulse    = ph(model[2 + op]);
        exp_busy = ph(model[1]) + 2 * ph(model[2]) + pulse + ph(model[8]);
        exp_busy = exp_busy + ph(model[(op == 3) ? 7 : 6]);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        busy_cnt = 0;
        apb(1'b1, IDX_CMD, 32'(op), rd, er);
        apb(1'b0, IDX_STATUS, 32'h0, rd, er);
        chk({28'h0, rd[3:0]}, {28'h0, 1'b0, 2'(op), 1'b1});
        apb(1'b1, IDX_CMD, 32'h00000001, rd, er);
        n = 0;
        while (op_done !== 1'b1 && n < 5000) begin
          @(posedge ref_clk);
          n++;
        end
        chk(32'(n < 5000), 32'h00000001);
        @(posedge ref_clk);
        chk(32'(busy_cnt), 32'(exp_busy));
        chk({16'h0, (op == 1) ? prog_len : erase_len}, 32'(pulse));
        chk({31'h0, sect_seen}, {31'h0, (op == 3)});
        apb(1'b0, IDX_STATUS, 32'h0, rd, er);
        chk({28'h0, rd[3], 2'b00, rd[0]}, 32'h00000008);
        apb(1'b1, IDX_STATUS, 32'h00000008, rd, er);
        apb(1'b0, IDX_STATUS, 32'h0, rd, er);
        chk({28'h0, rd[3:0]}, 32'h00000000);
      end
    end
    final_report;
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    final_report;
  end
endmodule
